// ==== logic/ugtt_config_top.sv ====
// usb_config_one register with gap timeout trim, scale-down select and gap timers
//
// Overview of operation
// - the high-speed trim times the per-clock bit-time factor is added to the HS gap timeout.
// - the untrimmed HS gap timeout lies within 736 to 816 bit times.
// - each HS trim clock adds 8 bit times, the clock being the 60 MHz PHY clock.
// - the full-speed trim times the per-clock bit-time factor is added to the FS gap timeout.
// - the untrimmed FS gap timeout lies within 16 to 18 bit times.
// - each FS trim clock adds 0.2 bit times.
// - the 2-bit scale select picks real timing, core timers, suspend/resume, or both shortened.
// - trim defaults come from eeprom if present, else otp, else zero.
// - a usb bus reset or lite reset reloads the trims from the last loaded image.
module ugtt_config_top
  import ugtt_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [31:0]       regRdData,
  input  wire ugtt_image_src_t   imageSrc,
  input  wire logic              imageLoad,
  input  wire logic              usbBusReset,
  input  wire logic              liteSoftReset,
  input  wire logic              hsGapStart,
  input  wire logic              fsGapStart,
  output logic                   hsGapExpired,
  output logic                   fsGapExpired,
  output logic      [9:0]        hsGapTimeoutBits,
  output logic      [7:0]        fsGapTimeoutTenths,
  output logic                   scaleCoreTimers,
  output logic                   scaleSuspendResume
);

  ugtt_top_t   top_reg;
  ugtt_top_t   top_next;
  ugtt_image_t image;
  logic        imageLoaded;
  logic        hitCfg;
  logic        reload;
  logic [31:0] readWord;

  ugtt_image_select u_image (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .imageSrc    (imageSrc),
    .imageLoad   (imageLoad),
    .image       (image),
    .imageLoaded (imageLoaded)
  );

  assign hitCfg = (regAddr == CFG_ONE_OFFSET);
  // a fresh image, a bus reset and a lite reset all restore the image trims
  assign reload = imageLoaded || usbBusReset || liteSoftReset;

  always_comb begin
    readWord                          = 32'h00000000;
    readWord[HS_TRIM_MSB:HS_TRIM_LSB] = top_reg.cfg.hsTrim;
    readWord[FS_TRIM_MSB:FS_TRIM_LSB] = top_reg.cfg.fsTrim;
    readWord[SCALE_MSB:SCALE_LSB]     = top_reg.cfg.scale;
  end

  always_comb begin
    top_next = top_reg;
    // only the defined fields are taken from a write
    if (regWrEn && hitCfg) begin
      top_next.cfg.hsTrim = regWrData[HS_TRIM_MSB:HS_TRIM_LSB];
      top_next.cfg.fsTrim = regWrData[FS_TRIM_MSB:FS_TRIM_LSB];
      top_next.cfg.scale  = regWrData[SCALE_MSB:SCALE_LSB];
    end
    // reload beats a software write of the trims in the same cycle
    if (reload) begin
      top_next.cfg.hsTrim = image.hsTrim;
      top_next.cfg.fsTrim = image.fsTrim;
    end
    top_next.rdData = 32'h00000000;
    if (regRdEn && hitCfg) begin
      top_next.rdData = readWord & ~CFG_ONE_RSVD_MASK;
    end
    top_next.hsTimeoutBits   = HS_BASE_BIT_TIMES
                             + 10'(top_reg.cfg.hsTrim) * HS_BITS_PER_CLOCK;
    top_next.hsLimit         = HS_BASE_CLOCKS + 8'(top_reg.cfg.hsTrim);
    top_next.fsTimeoutTenths = FS_BASE_TENTHS
                             + 8'(top_reg.cfg.fsTrim) * FS_TENTHS_PER_CLK;
    top_next.fsLimit         = FS_BASE_CLOCKS + 8'(top_reg.cfg.fsTrim);
    top_next.scaleCore       = top_reg.cfg.scale[SCALE_CORE_BIT];
    top_next.scaleSusp       = top_reg.cfg.scale[SCALE_SUSP_BIT];
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      top_reg <= '{cfg:             '{hsTrim: TRIM_BLANK, fsTrim: TRIM_BLANK,
                                      scale: SCALE_RESET},
                   rdData:          32'h00000000,
                   hsTimeoutBits:   HS_BASE_BIT_TIMES,
                   fsTimeoutTenths: FS_BASE_TENTHS,
                   hsLimit:         HS_BASE_CLOCKS,
                   fsLimit:         FS_BASE_CLOCKS,
                   scaleCore:       1'b0,
                   scaleSusp:       1'b0};
    end else begin
      top_reg <= top_next;
    end
  end

  ugtt_gap_timer u_hs_gap (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (hsGapStart),
    .limit   (top_reg.hsLimit),
    .expired (hsGapExpired)
  );

  ugtt_gap_timer u_fs_gap (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (fsGapStart),
    .limit   (top_reg.fsLimit),
    .expired (fsGapExpired)
  );

  assign regRdData          = top_reg.rdData;
  assign hsGapTimeoutBits   = top_reg.hsTimeoutBits;
  assign fsGapTimeoutTenths = top_reg.fsTimeoutTenths;
  assign scaleCoreTimers    = top_reg.scaleCore;
  assign scaleSuspendResume = top_reg.scaleSusp;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  chk_hs_trim_sum :
  assert property (##1 hsGapTimeoutBits
                   == HS_BASE_BIT_TIMES + 10'($past(top_reg.cfg.hsTrim)) * HS_BITS_PER_CLOCK)
    else $error("hs gap timeout is not base plus trim");

  chk_hs_base_range :
  assert property ((hsGapTimeoutBits - 10'(top_reg.hsLimit - HS_BASE_CLOCKS) * HS_BITS_PER_CLOCK
                    >= HS_STD_MIN_BITS)
                   && (hsGapTimeoutBits - 10'(top_reg.hsLimit - HS_BASE_CLOCKS) * HS_BITS_PER_CLOCK
                    <= HS_STD_MAX_BITS))
    else $error("untrimmed hs gap timeout out of range");

  chk_hs_clock_bits :
  assert property (10'(top_reg.hsLimit) * HS_BITS_PER_CLOCK == hsGapTimeoutBits)
    else $error("hs gap limit does not match eight bit times per clock");

  chk_fs_trim_sum :
  assert property (##1 fsGapTimeoutTenths
                   == FS_BASE_TENTHS + 8'($past(top_reg.cfg.fsTrim)) * FS_TENTHS_PER_CLK)
    else $error("fs gap timeout is not base plus trim");

  chk_fs_base_range :
  assert property ((fsGapTimeoutTenths - (top_reg.fsLimit - FS_BASE_CLOCKS) * FS_TENTHS_PER_CLK
                    >= FS_STD_MIN_TENTHS)
                   && (fsGapTimeoutTenths - (top_reg.fsLimit - FS_BASE_CLOCKS) * FS_TENTHS_PER_CLK
                    <= FS_STD_MAX_TENTHS))
    else $error("untrimmed fs gap timeout out of range");

  chk_fs_clock_bits :
  assert property (top_reg.fsLimit * FS_TENTHS_PER_CLK == fsGapTimeoutTenths)
    else $error("fs gap limit does not match two tenths per clock");

  chk_scale_select :
  assert property ((regWrEn && hitCfg) |=> ##1
                   ({scaleSuspendResume, scaleCoreTimers} == $past(regWrData[1:0], 2)))
    else $error("scale-down outputs do not follow the written select");

  chk_reset_reload :
  assert property ((usbBusReset || liteSoftReset) |=>
                   (top_reg.cfg.hsTrim == $past(image.hsTrim))
                   && (top_reg.cfg.fsTrim == $past(image.fsTrim)))
    else $error("trims not restored from image on usb or lite reset");

  chk_reserved_zero :
  assert property ((regRdData & CFG_ONE_RSVD_MASK) == 32'h00000000)
    else $error("reserved bits read nonzero");

  chk_read_window :
  assert property (!$past(regRdEn && hitCfg) |-> regRdData == 32'h00000000)
    else $error("read data present outside the read answer cycle");

  chk_write_fields :
  assert property ((regWrEn && hitCfg && !reload) |=>
                   (top_reg.cfg.hsTrim == $past(regWrData[HS_TRIM_MSB:HS_TRIM_LSB]))
                   && (top_reg.cfg.fsTrim == $past(regWrData[FS_TRIM_MSB:FS_TRIM_LSB])))
    else $error("trim fields not taken from the register write");

  chk_write_elsewhere :
  assert property ((regWrEn && !hitCfg && !reload) |=> $stable(top_reg.cfg))
    else $error("write to another address changed the configuration");

  chk_cfg_hold :
  assert property ((!regWrEn && !reload) |=> $stable(top_reg.cfg))
    else $error("configuration changed without a write or reload");

  chk_image_apply :
  assert property (imageLoaded |=> (top_reg.cfg.hsTrim == $past(image.hsTrim))
                   && (top_reg.cfg.fsTrim == $past(image.fsTrim)))
    else $error("latched image not applied to the trims");

  chk_reload_scale :
  assert property ((reload && !(regWrEn && hitCfg)) |=> $stable(top_reg.cfg.scale))
    else $error("scale select disturbed by a trim reload");

  chk_scale_decode :
  assert property ((scaleCoreTimers == $past(top_reg.cfg.scale[SCALE_CORE_BIT]))
                   && (scaleSuspendResume == $past(top_reg.cfg.scale[SCALE_SUSP_BIT])))
    else $error("scale outputs do not decode the select");

  chk_read_fields :
  assert property ((regRdEn && hitCfg) |=>
                   (regRdData[HS_TRIM_MSB:HS_TRIM_LSB] == $past(top_reg.cfg.hsTrim))
                   && (regRdData[FS_TRIM_MSB:FS_TRIM_LSB] == $past(top_reg.cfg.fsTrim))
                   && (regRdData[SCALE_MSB:SCALE_LSB] == $past(top_reg.cfg.scale)))
    else $error("read data does not show the stored fields");

  chk_unmapped_read :
  assert property ((regRdEn && !hitCfg) |=> regRdData == 32'h00000000)
    else $error("read of another address returned data");

  chk_hs_limit_span :
  assert property ((top_reg.hsLimit >= HS_BASE_CLOCKS)
                   && (top_reg.hsLimit <= HS_BASE_CLOCKS + 8'h07))
    else $error("hs gap limit outside base plus trim span");

  chk_fs_limit_span :
  assert property ((top_reg.fsLimit >= FS_BASE_CLOCKS)
                   && (top_reg.fsLimit <= FS_BASE_CLOCKS + 8'h07))
    else $error("fs gap limit outside base plus trim span");

endmodule

// ==== logic/ugtt_gap_timer.sv ====
// counts clocks after a packet end and pulses when the gap limit is reached
module ugtt_gap_timer
  import ugtt_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               start,
  input  wire logic [TIMER_W-1:0] limit,
  output logic                    expired
);

  ugtt_timer_t tmr_reg;
  ugtt_timer_t tmr_next;
  logic [TIMER_W-1:0] countInc;

  assign countInc = tmr_reg.count + TIMER_W'(1);

  always_comb begin
    tmr_next         = tmr_reg;
    tmr_next.expired = 1'b0;
    if (start) begin
      // a new packet end restarts the gap
      tmr_next.count   = '0;
      tmr_next.running = 1'b1;
    end else if (tmr_reg.running) begin
      tmr_next.count = countInc;
      if (countInc >= limit) begin
        tmr_next.running = 1'b0;
        tmr_next.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tmr_reg <= '{count: '0, running: 1'b0, expired: 1'b0};
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  assign expired = tmr_reg.expired;

  chk_gap_restart :
  assert property (@(posedge sys_clk) disable iff (!resetn)
    (start && limit > TIMER_W'(1)) |=> !expired ##1 !expired)
    else $error("gap expired too soon after a packet end");

endmodule

// ==== logic/ugtt_image_select.sv ====
// latches the trim image from eeprom, otp or the blank default
module ugtt_image_select
  import ugtt_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  input  wire ugtt_image_src_t imageSrc,
  input  wire logic            imageLoad,
  output ugtt_image_t          image,
  output logic                 imageLoaded
);

  ugtt_img_state_t img_reg;
  ugtt_img_state_t img_next;
  ugtt_image_t     pick;

  always_comb begin
    pick = '{hsTrim: TRIM_BLANK, fsTrim: TRIM_BLANK};
    if (imageSrc.eepromPresent) begin
      pick = '{hsTrim: imageSrc.eepromHsTrim, fsTrim: imageSrc.eepromFsTrim};
    end else if (imageSrc.otpProgrammed) begin
      pick = '{hsTrim: imageSrc.otpHsTrim, fsTrim: imageSrc.otpFsTrim};
    end
  end

  always_comb begin
    img_next        = img_reg;
    img_next.loaded = 1'b0;
    if (imageLoad) begin
      img_next.image  = pick;
      img_next.loaded = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      img_reg <= '{image: '{hsTrim: TRIM_BLANK, fsTrim: TRIM_BLANK}, loaded: 1'b0};
    end else begin
      img_reg <= img_next;
    end
  end

  assign image       = img_reg.image;
  assign imageLoaded = img_reg.loaded;

  chk_image_pick :
  assert property (@(posedge sys_clk) disable iff (!resetn)
    imageLoad |=> (image == $past(pick)) && imageLoaded)
    else $error("image not taken from the preferred source");

endmodule

// ==== logic/ugtt_pkg.sv ====
// shared constants and carrier types of the gap timeout trim configuration register
package ugtt_pkg;

  // register map
  localparam int unsigned    ADDR_W             = 12;
  localparam logic [11:0]    CFG_ONE_OFFSET     = 12'h084;

  // field layout of usb_config_one
  localparam int unsigned    HS_TRIM_MSB        = 15;
  localparam int unsigned    HS_TRIM_LSB        = 13;
  localparam int unsigned    FS_TRIM_MSB        = 6;
  localparam int unsigned    FS_TRIM_LSB        = 4;
  localparam int unsigned    SCALE_MSB          = 1;
  localparam int unsigned    SCALE_LSB          = 0;
  localparam logic [31:0]    CFG_ONE_RSVD_MASK  = 32'hFFFF1F8C;

  // reset and blank-image values
  localparam logic [2:0]     TRIM_BLANK         = 3'h0;
  localparam logic [1:0]     SCALE_RESET        = 2'h0;

  // scale-down select bit positions
  localparam int unsigned    SCALE_CORE_BIT     = 0;
  localparam int unsigned    SCALE_SUSP_BIT     = 1;

  // high-speed gap timing, in bit times
  localparam logic [9:0]     HS_STD_MIN_BITS    = 10'h2E0;
  localparam logic [9:0]     HS_STD_MAX_BITS    = 10'h330;
  localparam logic [9:0]     HS_BASE_BIT_TIMES  = 10'h2E0;
  localparam logic [9:0]     HS_BITS_PER_CLOCK  = 10'h008;
  localparam logic [7:0]     HS_BASE_CLOCKS     = 8'(HS_BASE_BIT_TIMES / HS_BITS_PER_CLOCK);

  // full-speed gap timing, in tenths of a bit time
  localparam logic [7:0]     FS_STD_MIN_TENTHS  = 8'hA0;
  localparam logic [7:0]     FS_STD_MAX_TENTHS  = 8'hB4;
  localparam logic [7:0]     FS_BASE_TENTHS     = 8'hA0;
  localparam logic [7:0]     FS_TENTHS_PER_CLK  = 8'h02;
  localparam logic [7:0]     FS_BASE_CLOCKS     = 8'(FS_BASE_TENTHS / FS_TENTHS_PER_CLK);

  localparam int unsigned    TIMER_W            = 8;

  // configuration image as offered by the loader
  typedef struct packed {
    logic       eepromPresent;
    logic       otpProgrammed;
    logic [2:0] eepromHsTrim;
    logic [2:0] eepromFsTrim;
    logic [2:0] otpHsTrim;
    logic [2:0] otpFsTrim;
  } ugtt_image_src_t;

  typedef struct packed {
    logic [2:0] hsTrim;
    logic [2:0] fsTrim;
  } ugtt_image_t;

  typedef struct packed {
    ugtt_image_t image;
    logic        loaded;
  } ugtt_img_state_t;

  typedef struct packed {
    logic [2:0] hsTrim;
    logic [2:0] fsTrim;
    logic [1:0] scale;
  } ugtt_cfg_t;

  typedef struct packed {
    logic [TIMER_W-1:0] count;
    logic               running;
    logic               expired;
  } ugtt_timer_t;

  typedef struct packed {
    ugtt_cfg_t   cfg;
    logic [31:0] rdData;
    logic [9:0]  hsTimeoutBits;
    logic [7:0]  fsTimeoutTenths;
    logic [7:0]  hsLimit;
    logic [7:0]  fsLimit;
    logic        scaleCore;
    logic        scaleSusp;
  } ugtt_top_t;

endpackage

// ==== tb/tb_top.sv ====
// self-checking bench of the gap timeout trim configuration register
module tb_top
  import ugtt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic            sys_clk = 1'b0;
  logic            resetn = 1'b0;
  logic [11:0]     regAddr = 12'h000;
  logic [31:0]     regWrData = 32'h0;
  logic            regWrEn = 1'b0;
  logic            regRdEn = 1'b0;
  logic [31:0]     regRdData;
  ugtt_image_src_t imageSrc = '0;
  logic            imageLoad = 1'b0;
  logic            usbBusReset = 1'b0;
  logic            liteSoftReset = 1'b0;
  logic            hsGapStart, fsGapStart, hsGapExpired, fsGapExpired;
  logic [9:0]      hsGapTimeoutBits;
  logic [7:0]      fsGapTimeoutTenths;
  logic            scaleCoreTimers, scaleSuspendResume;
  logic            sendHs = 1'b0;
  logic            sendFs = 1'b0;
  logic [7:0]      gapCycles;
  int              n_fail = 0;
  int              checks = 0;
  int              cyc = 0;

  ugtt_config_top uut (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .imageSrc(imageSrc), .imageLoad(imageLoad), .usbBusReset(usbBusReset),
    .liteSoftReset(liteSoftReset), .hsGapStart(hsGapStart), .fsGapStart(fsGapStart),
    .hsGapExpired(hsGapExpired), .fsGapExpired(fsGapExpired),
    .hsGapTimeoutBits(hsGapTimeoutBits), .fsGapTimeoutTenths(fsGapTimeoutTenths),
    .scaleCoreTimers(scaleCoreTimers), .scaleSuspendResume(scaleSuspendResume));

  ugtt_host_model host (.sys_clk(sys_clk), .sendHs(sendHs), .sendFs(sendFs),
    .gapExpired(hsGapExpired | fsGapExpired), .hsGapStart(hsGapStart),
    .fsGapStart(fsGapStart), .gapCycles(gapCycles));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  function automatic logic [31:0] word(input logic [2:0] h, input logic [2:0] f,
                                       input logic [1:0] s);
    return {16'h0000, h, 6'h00, f, 2'h0, s};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 chk("regRdData", exp, regRdData);
  endtask

  // timeout outputs: 736 + 8 per hs trim clock, 160 tenths + 2 tenths per fs trim clock
  task automatic outs(input logic [2:0] h, input logic [2:0] f, input logic [1:0] s);
    repeat (3) @(posedge sys_clk);
    #1 chk("hsGapTimeoutBits", 32'(HS_BASE_BIT_TIMES + HS_BITS_PER_CLOCK * h),
           32'(hsGapTimeoutBits));
    chk("fsGapTimeoutTenths", 32'(FS_BASE_TENTHS + FS_TENTHS_PER_CLK * f),
        32'(fsGapTimeoutTenths));
    chk("scaleOutputs", 32'(s), 32'({scaleSuspendResume, scaleCoreTimers}));
  endtask

  task automatic gap(input logic hs, input logic [7:0] exp);
    @(posedge sys_clk);
    sendHs <= hs;
    sendFs <= !hs;
    @(posedge sys_clk);
    sendHs <= 1'b0;
    sendFs <= 1'b0;
    repeat (120) @(posedge sys_clk);
    #1 chk("gapCycles", 32'(exp), 32'(gapCycles));
  endtask

  task automatic img(input ugtt_image_src_t src);
    @(posedge sys_clk);
    imageSrc <= src;
    imageLoad <= 1'b1;
    @(posedge sys_clk);
    imageLoad <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic reload(input logic bus);
    @(posedge sys_clk);
    usbBusReset <= bus;
    liteSoftReset <= !bus;
    @(posedge sys_clk);
    usbBusReset <= 1'b0;
    liteSoftReset <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(CFG_ONE_OFFSET, 32'h0);
    outs(3'h0, 3'h0, 2'h0);
    $display("test reset done");
    wr(CFG_ONE_OFFSET, 32'hFFFFFFFF);
    rd(CFG_ONE_OFFSET, word(3'h7, 3'h7, 2'h3));
    outs(3'h7, 3'h7, 2'h3);
    wr(12'h088, 32'h0);
    rd(12'h080, 32'h0);
    rd(CFG_ONE_OFFSET, word(3'h7, 3'h7, 2'h3));
    $display("test fields done");
    wr(CFG_ONE_OFFSET, word(3'h3, 3'h5, 2'h0));
    gap(1'b1, HS_BASE_CLOCKS + 8'h03);
    gap(1'b0, FS_BASE_CLOCKS + 8'h05);
    $display("test gap timers done");
    for (int i = 0; i < 4; i++) begin
      wr(CFG_ONE_OFFSET, word(3'h0, 3'h0, 2'(i)));
      outs(3'h0, 3'h0, 2'(i));
    end
    $display("test scale select done");
    img('{1'b1, 1'b1, 3'h5, 3'h3, 3'h2, 3'h6});
    rd(CFG_ONE_OFFSET, word(3'h5, 3'h3, 2'h3));
    wr(CFG_ONE_OFFSET, word(3'h1, 3'h1, 2'h0));
    reload(1'b1);
    rd(CFG_ONE_OFFSET, word(3'h5, 3'h3, 2'h0));
    wr(CFG_ONE_OFFSET, word(3'h2, 3'h2, 2'h0));
    reload(1'b0);
    rd(CFG_ONE_OFFSET, word(3'h5, 3'h3, 2'h0));
    img('{1'b0, 1'b1, 3'h5, 3'h3, 3'h2, 3'h6});
    rd(CFG_ONE_OFFSET, word(3'h2, 3'h6, 2'h0));
    img('{1'b0, 1'b0, 3'h5, 3'h3, 3'h2, 3'h6});
    rd(CFG_ONE_OFFSET, word(3'h0, 3'h0, 2'h0));
    wr(CFG_ONE_OFFSET, word(3'h7, 3'h4, 2'h0));
    reload(1'b1);
    rd(CFG_ONE_OFFSET, word(3'h0, 3'h0, 2'h0));
    $display("test image reload done");
    wr(CFG_ONE_OFFSET, 32'h0);
    end_sim();
  end
endmodule

// ==== tb/ugtt_host_model.sv ====
// usb host side model: sends packet ends and measures the device gap timeout in clocks
module ugtt_host_model (
  input  wire logic       sys_clk,
  input  wire logic       sendHs,
  input  wire logic       sendFs,
  input  wire logic       gapExpired,
  output logic            hsGapStart,
  output logic            fsGapStart,
  output logic      [7:0] gapCycles
);
  timeunit 1ns;
  timeprecision 1ns;
  logic waiting = 1'b0;
  // counts clocks from the packet end taken by the device until its expiry pulse
  always @(posedge sys_clk) begin
    hsGapStart <= sendHs;
    fsGapStart <= sendFs;
    if (hsGapStart || fsGapStart) begin
      gapCycles <= 8'h00;
      waiting <= 1'b1;
    end else if (waiting && gapExpired) begin
      waiting <= 1'b0;
    end else if (waiting) begin
      gapCycles <= gapCycles + 8'h01;
    end
  end
endmodule
